// file: rtl/rpm_pkg.sv
// rpm_pkg: constants, register map and carrier types of the reset and power mode block
// assumes a single 100 MHz system clock and an 8-bit special-function register port
package rpm_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] RPM_ADDR_CAUSE  = 8'h86;
  localparam logic [7:0] RPM_ADDR_PMODE  = 8'h87;
  localparam logic [7:0] RPM_CAUSE_RST   = 8'h81;
  localparam logic [7:0] RPM_PMODE_RST   = 8'h00;
  localparam logic [7:0] RPM_PMODE_IDLE  = 8'h01;
  localparam logic [7:0] RPM_PMODE_DEEP  = 8'h03;
  localparam int         RPM_BIT_PWRF    = 7;
  localparam int         RPM_BIT_EXTF    = 6;
  localparam int         RPM_BIT_WDTF    = 5;
  localparam int         RPM_BIT_DBGF    = 4;
  localparam int         RPM_BIT_BODF    = 3;
  localparam int         RPM_BIT_LVL_HI  = 2;
  localparam int         RPM_BIT_LVL_LO  = 1;
  localparam int         RPM_BIT_BO_EN   = 0;

  // ----------------------------------------------------------------
  // reset state of the processor core
  // ----------------------------------------------------------------
  localparam logic [15:0] RPM_PC_RST  = 16'h0000;
  localparam logic [7:0]  RPM_ACC_RST = 8'h00;
  localparam logic [7:0]  RPM_SP_RST  = 8'h07;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          RPM_CLK_MHZ       = 100;
  localparam int          RPM_FILTER_NS     = 7000;
  localparam int          RPM_FILTER_CYC    = RPM_FILTER_NS * RPM_CLK_MHZ / 1000;
  localparam int          RPM_LSOSC_KHZ     = 125;
  localparam int          RPM_LS_PRESCALE   = 32;
  localparam int          RPM_LS_TICK_CYC   = RPM_CLK_MHZ * 1000 / RPM_LSOSC_KHZ
                                              * RPM_LS_PRESCALE;
  localparam logic [5:0]  RPM_BOOT_TICKS    = 6'h30;
  localparam int          RPM_RELEASE_MS    = 16;
  localparam int          RPM_RELEASE_CYC   = RPM_RELEASE_MS * RPM_CLK_MHZ * 1000;
  localparam logic [2:0]  RPM_PROC_CLKS     = 3'h5;

  typedef enum logic [2:0] {
    RPM_ST_HOLD = 3'b000,
    RPM_ST_BOOT = 3'b001,
    RPM_ST_REL  = 3'b010,
    RPM_ST_PROC = 3'b011,
    RPM_ST_RUN  = 3'b100
  } rpm_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rpm_bus_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  acc;
    logic [7:0]  sp;
  } rpm_core_rst_t;

  typedef struct packed {
    logic main_osc_en;
    logic sys_clk_en;
    logic periph_clk_en;
    logic lsosc_en;
    logic cpu_clk_en;
  } rpm_clk_ctl_t;

endpackage : rpm_pkg

// file: rtl/rpm_top.sv
// rpm_top: reset sequencing, reset cause flags, brown-out control and power modes
// assumes event inputs from on-chip logic are synchronous to clk_sys;
// the reset pin and the brown-out comparator are asynchronous and synchronised here
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps

module rpm_top
  import rpm_pkg::*;
#(
  parameter int REL_CYC  = rpm_pkg::RPM_RELEASE_CYC,
  parameter int TICK_CYC = rpm_pkg::RPM_LS_TICK_CYC
) (
  input  wire logic           clk_sys,
  input  wire logic           rst,
  input  wire rpm_pkg::rpm_bus_t bus,
  output      logic [7:0]     rdata,
  input  wire logic           external_reset_pin_n,
  input  wire logic           pin_gpio_mode,
  output      logic           pin_gpio_in,
  input  wire logic           watchdog_overflow,
  input  wire logic           watchdog_reset_enable,
  input  wire logic           brownout_trip,
  input  wire logic           debug_reset_req,
  input  wire logic           wake_irq,
  input  wire logic           sysclk_lowspeed_keep,
  output      logic           sys_reset,
  output      logic           config_read,
  output      rpm_pkg::rpm_core_rst_t core_rst,
  output      rpm_pkg::rpm_clk_ctl_t  clk_ctl,
  output      logic [1:0]     brownout_level_select,
  output      logic           brownout_enable,
  output      logic           idle_mode,
  output      logic           deep_sleep
);
  import rpm_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pin_sync_q;
  logic [1:0] bod_sync_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_sync_q <= 2'h3;
      bod_sync_q <= 2'h0;
    end else begin
      pin_sync_q <= {pin_sync_q[0], external_reset_pin_n};
      bod_sync_q <= {bod_sync_q[0], brownout_trip};
    end
  end

  logic pin_s;
  logic bod_s;
  assign pin_s = pin_sync_q[1];
  assign bod_s = bod_sync_q[1];

  // ----------------------------------------------------------------
  // reset pin noise filter
  // ----------------------------------------------------------------
  // a low is believed only after it has stood for the full window
  localparam int FW = $clog2(RPM_FILTER_CYC + 1);
  logic [FW-1:0] filt_q;
  logic          ext_low_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      filt_q    <= '0;
      ext_low_q <= 1'b0;
    end else if (pin_gpio_mode || pin_s) begin
      filt_q    <= '0;
      ext_low_q <= 1'b0;
    end else if (filt_q == FW'(RPM_FILTER_CYC - 1)) begin
      ext_low_q <= 1'b1;
    end else begin
      filt_q <= filt_q + FW'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_gpio_in <= 1'b1;
    end else begin
      pin_gpio_in <= pin_s;
    end
  end

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  logic bo_en_q;
  logic ext_evt;
  logic wdt_evt;
  logic bod_evt;
  logic dbg_evt;
  logic src_any;

  assign ext_evt = ext_low_q;
  assign wdt_evt = watchdog_overflow && watchdog_reset_enable;
  assign bod_evt = bod_s && bo_en_q;
  assign dbg_evt = debug_reset_req;
  assign src_any = ext_evt || wdt_evt || bod_evt || dbg_evt;

  // ----------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------
  localparam int CW = $clog2(REL_CYC + 1);
  localparam int TW = $clog2(TICK_CYC + 1);
  rpm_state_t    state_q;
  logic [CW-1:0] cnt_q;
  logic [TW-1:0] div_q;
  logic [5:0]    ticks_q;
  logic [2:0]    proc_q;
  logic          tick;
  logic          rel_done;

  // slow boot ticks: low-speed oscillator rate divided by the prescaler
  assign tick     = (div_q == TW'(TICK_CYC - 1));
  assign rel_done = (cnt_q == CW'(REL_CYC - 1));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_q <= '0;
    end else if (state_q != RPM_ST_BOOT || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + TW'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q     <= RPM_ST_BOOT;
      cnt_q       <= '0;
      ticks_q     <= 6'h00;
      proc_q      <= 3'h0;
      config_read <= 1'b0;
    end else begin
      config_read <= 1'b0;
      if (src_any) begin
        state_q <= RPM_ST_HOLD;
        cnt_q   <= '0;
        proc_q  <= 3'h0;
      end else begin
        unique case (state_q)
          RPM_ST_HOLD: begin
            state_q <= RPM_ST_REL;
            cnt_q   <= '0;
          end
          RPM_ST_BOOT: begin
            cnt_q <= cnt_q + CW'(1);
            if (tick) begin
              ticks_q <= ticks_q + 6'h01;
              if (ticks_q == RPM_BOOT_TICKS - 6'h01) begin
                config_read <= 1'b1;
                state_q     <= RPM_ST_REL;
              end
            end
          end
          RPM_ST_REL: begin
            // the 16ms window runs from power-on, or from the end of the last active reset source (pin, watchdog, debugger or brown-out)
            if (rel_done) begin
              state_q <= RPM_ST_PROC;
              cnt_q   <= '0;
            end else begin
              cnt_q <= cnt_q + CW'(1);
            end
          end
          RPM_ST_PROC: begin
            if (proc_q == RPM_PROC_CLKS - 3'h1) begin
              state_q <= RPM_ST_RUN;
            end else begin
              proc_q <= proc_q + 3'h1;
            end
          end
          RPM_ST_RUN: begin
            proc_q <= 3'h0;
          end
          default: begin
            state_q <= RPM_ST_HOLD;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sys_reset <= 1'b1;
    end else begin
      sys_reset <= (state_q != RPM_ST_RUN) || src_any;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      core_rst <= '{pc: RPM_PC_RST, acc: RPM_ACC_RST, sp: RPM_SP_RST};
    end else if (state_q != RPM_ST_RUN) begin
      core_rst <= '{pc: RPM_PC_RST, acc: RPM_ACC_RST, sp: RPM_SP_RST};
    end
  end

  // ----------------------------------------------------------------
  // reset cause and brown-out control register
  // ----------------------------------------------------------------
  logic [4:0] flags_q;
  logic [1:0] lvl_q;
  logic       wr_cause;
  logic       wr_pmode;
  logic [4:0] flag_set;
  logic [4:0] flag_keep;

  assign wr_cause  = bus.wr && bus.addr == RPM_ADDR_CAUSE;
  assign wr_pmode  = bus.wr && bus.addr == RPM_ADDR_PMODE && state_q == RPM_ST_RUN;
  assign flag_set  = {1'b0, ext_evt, wdt_evt, dbg_evt, bod_evt};
  // writing 1 keeps a flag, writing 0 clears it; a new event wins over the clear
  assign flag_keep = wr_cause ? (flags_q & bus.wdata[7:3]) : flags_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags_q <= RPM_CAUSE_RST[7:3];
    end else begin
      flags_q <= flag_keep | flag_set;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lvl_q   <= RPM_CAUSE_RST[RPM_BIT_LVL_HI:RPM_BIT_LVL_LO];
      bo_en_q <= RPM_CAUSE_RST[RPM_BIT_BO_EN];
    end else if (state_q == RPM_ST_HOLD) begin
      bo_en_q <= 1'b1;
    end else if (wr_cause) begin
      lvl_q   <= bus.wdata[RPM_BIT_LVL_HI:RPM_BIT_LVL_LO];
      bo_en_q <= bus.wdata[RPM_BIT_BO_EN];
    end
  end

  assign brownout_level_select = lvl_q;
  assign brownout_enable       = bo_en_q;

  // ----------------------------------------------------------------
  // power mode register
  // ----------------------------------------------------------------
  logic [7:0] pmode_q;
  logic       keep_ls_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pmode_q <= RPM_PMODE_RST;
    end else if (state_q != RPM_ST_RUN || src_any) begin
      pmode_q <= RPM_PMODE_RST;
    end else if (wr_pmode) begin
      pmode_q <= bus.wdata;
    end else if (wake_irq && (idle_mode || deep_sleep)) begin
      pmode_q <= RPM_PMODE_RST;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      keep_ls_q <= 1'b1;
    end else if (wr_pmode && bus.wdata == RPM_PMODE_DEEP) begin
      keep_ls_q <= sysclk_lowspeed_keep;
    end
  end

  assign idle_mode  = (pmode_q == RPM_PMODE_IDLE);
  assign deep_sleep = (pmode_q == RPM_PMODE_DEEP);

  // registers and ram are never cleared by sleep, only their clocks stop
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk_ctl <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    end else begin
      clk_ctl.main_osc_en   <= !deep_sleep;
      clk_ctl.sys_clk_en    <= !deep_sleep;
      clk_ctl.periph_clk_en <= !deep_sleep;
      clk_ctl.lsosc_en      <= !deep_sleep || keep_ls_q;
      clk_ctl.cpu_clk_en    <= !deep_sleep && !idle_mode && state_q == RPM_ST_RUN;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        RPM_ADDR_CAUSE: rdata <= {flags_q, lvl_q, bo_en_q};
        RPM_ADDR_PMODE: rdata <= pmode_q;
        default:        rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_idle_entry: assert property (
    wr_pmode && bus.wdata == RPM_PMODE_IDLE && !src_any && state_q == RPM_ST_RUN
    |=> idle_mode ##1 !clk_ctl.cpu_clk_en && clk_ctl.sys_clk_en)
    else $error("idle write did not halt the cpu");

  a_deep_entry: assert property (
    wr_pmode && bus.wdata == RPM_PMODE_DEEP && !src_any
    |=> deep_sleep ##1 !clk_ctl.main_osc_en)
    else $error("deep sleep write did not stop clocks");

  a_deep_wake: assert property (
    deep_sleep && wake_irq && !wr_pmode |=> pmode_q == 8'h00)
    else $error("power mode not cleared on wake");

  a_variant_pick: assert property (
    wr_pmode && bus.wdata == RPM_PMODE_DEEP && !src_any
    |=> ##1 clk_ctl.lsosc_en == $past(sysclk_lowspeed_keep, 2))
    else $error("deep sleep variant wrong");

  a_reset_vec: assert property (
    state_q == RPM_ST_PROC |=> core_rst.sp == RPM_SP_RST && core_rst.pc == RPM_PC_RST)
    else $error("reset vector not loaded");

  a_wdt_gate: assert property (
    state_q == RPM_ST_RUN && !watchdog_reset_enable && !ext_evt && !bod_evt
    && !dbg_evt |=> state_q != RPM_ST_HOLD)
    else $error("disabled watchdog caused a reset");

  a_filter_short: assert property (
    $rose(!pin_s) && !pin_gpio_mode ##1 pin_s |-> !ext_low_q [*3])
    else $error("short reset pin pulse accepted");

  a_proc_five: assert property (
    $rose(state_q == RPM_ST_PROC) ##0 !src_any [*5] |=> state_q == RPM_ST_RUN)
    else $error("reset processing not five clocks");

  a_flag_keep: assert property (
    wr_cause && bus.wdata[7:3] == 5'h1f |=> flags_q == $past(flags_q | flag_set))
    else $error("writing one changed a cause flag");

  a_set_wins: assert property (
    ext_evt |=> flags_q[RPM_BIT_EXTF - 3])
    else $error("pin flag lost");

  a_lvl_write: assert property (
    wr_cause && state_q != RPM_ST_HOLD |=> lvl_q == $past(bus.wdata[2:1]))
    else $error("level field not written");

  c_boot_done:  cover property (config_read);
  c_idle_wake:  cover property (idle_mode && wake_irq);
  c_deep_wake:  cover property (deep_sleep && wake_irq);
  c_pin_reset:  cover property ($rose(ext_low_q));

endmodule : rpm_top

// file: verif/rpm_top_tb.sv
// rpm_top_tb: self-checking bench for the reset and power mode block
// assumes shortened release and tick counts; the bench drives every port itself
`timescale 1ns/1ps

module rpm_top_tb;
  import rpm_pkg::*;

  // ----------------------------------------------------------------
  // signals and instance
  // ----------------------------------------------------------------
  localparam int REL = 200;
  localparam int TCK = 2;

  logic          clk_sys;
  logic          rst;
  rpm_bus_t      bus;
  logic [7:0]    rdata;
  logic          pin_n, gpio_mode, gpio_in, wdt_ovf, wdt_en, bo_trip, dbg_req;
  logic          wake, ls_keep, sys_reset, config_read, bo_en, idle_mode, deep_sleep;
  rpm_core_rst_t core_rst;
  rpm_clk_ctl_t  clk_ctl;
  logic [1:0]    bo_lvl;
  int            n_errors = 0;
  int            total_checks = 0;
  int            cyc = 0;
  int            cfg_cnt = 0;
  int            cfg_at = 0;

  rpm_top #(.REL_CYC(REL), .TICK_CYC(TCK)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
    .external_reset_pin_n(pin_n), .pin_gpio_mode(gpio_mode), .pin_gpio_in(gpio_in),
    .watchdog_overflow(wdt_ovf), .watchdog_reset_enable(wdt_en),
    .brownout_trip(bo_trip), .debug_reset_req(dbg_req), .wake_irq(wake),
    .sysclk_lowspeed_keep(ls_keep), .sys_reset(sys_reset), .config_read(config_read),
    .core_rst(core_rst), .clk_ctl(clk_ctl), .brownout_level_select(bo_lvl),
    .brownout_enable(bo_en), .idle_mode(idle_mode), .deep_sleep(deep_sleep)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // boot pulse bookkeeping, counted from the last power-on release
  always @(posedge clk_sys) begin
    cyc <= rst ? 0 : cyc + 1;
    if (config_read === 1'b1) begin
      cfg_cnt <= cfg_cnt + 1;
      cfg_at  <= cyc;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // bounded wait on the internal reset; a hang ends the run
  task automatic wait_rst(input logic v, input int lim, output int n);
    n = 0;
    while (sys_reset !== v) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n > lim) begin
        n_errors++;
        $display("[FAIL] sys_reset wait expected %b seen %b", v, sys_reset);
        tally_and_finish();
      end
    end
  endtask : wait_rst

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1;
    check(what, {8'h00, rdata}, {8'h00, exp});
  endtask : rd_chk

  task automatic pulse_wake;
    @(posedge clk_sys);
    wake <= 1'b1;
    @(posedge clk_sys);
    wake <= 1'b0;
    #1;
  endtask : pulse_wake

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_power_on;
    int n;
    check("pc", core_rst.pc, RPM_PC_RST);
    check("acc sp", {core_rst.acc, core_rst.sp}, {RPM_ACC_RST, RPM_SP_RST});
    check("clk bo", {14'h0, clk_ctl.periph_clk_en, bo_en}, 16'h3);
    wait_rst(1'b0, REL + 50, n);
    check("por release", 16'(n >= REL + 4 && n <= REL + 10), 16'h1);
    check("boot pulses", 16'(cfg_cnt), 16'h1);
    check("boot time", 16'(cfg_at >= 48 * TCK - 2 && cfg_at <= 48 * TCK + 8), 16'h1);
    rd_chk(RPM_ADDR_CAUSE, RPM_CAUSE_RST, "cause reset");
    rd_chk(RPM_ADDR_PMODE, RPM_PMODE_RST, "pmode reset");
  endtask : t_power_on

  task automatic t_cause_bits;
    wr(RPM_ADDR_CAUSE, 8'h00);
    rd_chk(RPM_ADDR_CAUSE, 8'h00, "flags cleared");
    wr(RPM_ADDR_CAUSE, 8'hff);
    rd_chk(RPM_ADDR_CAUSE, 8'h07, "write one");
    for (int l = 0; l < 4; l++) begin
      wr(RPM_ADDR_CAUSE, 8'(l << 1));
      check("level", {14'h0, bo_lvl}, 16'(l));
    end
    rd_chk(8'h55, 8'h00, "unmapped");
  endtask : t_cause_bits

  task automatic t_idle;
    wr(RPM_ADDR_PMODE, RPM_PMODE_IDLE);
    check("idle", {14'h0, idle_mode, deep_sleep}, 16'h2);
    @(posedge clk_sys);
    #1;
    check("idle clocks", 16'(clk_ctl), 16'h1e);
    pulse_wake();
    check("idle end", {15'h0, idle_mode}, 16'h0);
  endtask : t_idle

  task automatic t_deep(input logic keep);
    wr(RPM_ADDR_CAUSE, 8'h00);
    @(posedge clk_sys);
    ls_keep <= keep;
    wr(RPM_ADDR_PMODE, RPM_PMODE_DEEP);
    check("deep", {14'h0, idle_mode, deep_sleep}, 16'h1);
    @(posedge clk_sys);
    #1;
    check("deep clocks", 16'(clk_ctl), {11'h0, 3'b000, keep, 1'b0});
    rd_chk(RPM_ADDR_CAUSE, 8'h00, "retained");
    pulse_wake();
    rd_chk(RPM_ADDR_PMODE, 8'h00, "deep wake");
    check("wake clocks", 16'(clk_ctl), 16'h1f);
  endtask : t_deep

  task automatic t_pin_reset;
    int n;
    wr(RPM_ADDR_CAUSE, 8'h00);
    wr(RPM_ADDR_PMODE, RPM_PMODE_DEEP);
    // a one-cycle glitch must be swallowed by the filter
    @(posedge clk_sys);
    pin_n <= 1'b0;
    @(posedge clk_sys);
    pin_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    check("glitch", {14'h0, sys_reset, deep_sleep}, 16'h1);
    @(posedge clk_sys);
    pin_n <= 1'b0;
    repeat (690) @(posedge clk_sys);
    #1;
    check("filtered", {15'h0, sys_reset}, 16'h0);
    wait_rst(1'b1, 40, n);
    check("deep by reset", {15'h0, deep_sleep}, 16'h0);
    @(posedge clk_sys);
    pin_n <= 1'b1;
    wait_rst(1'b0, REL + 40, n);
    check("pin release", 16'(n >= REL + 5 && n <= REL + 15), 16'h1);
    rd_chk(RPM_ADDR_CAUSE, 8'h41, "pin flag");
    rd_chk(RPM_ADDR_PMODE, 8'h00, "pmode reset");
  endtask : t_pin_reset

  // k: 0 watchdog, 1 debugger, 2 brown-out
  task automatic t_src(input int k, input logic en, input logic [7:0] exp);
    int n;
    wr(RPM_ADDR_CAUSE, {7'h00, en});
    @(posedge clk_sys);
    wdt_en  <= en;
    wdt_ovf <= (k == 0);
    dbg_req <= (k == 1);
    bo_trip <= (k == 2);
    @(posedge clk_sys);
    wdt_ovf <= 1'b0;
    dbg_req <= 1'b0;
    repeat (3) @(posedge clk_sys);
    bo_trip <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    check("reset taken", {15'h0, sys_reset}, 16'(en));
    wait_rst(1'b0, REL + 40, n);
    rd_chk(RPM_ADDR_CAUSE, exp, "cause flag");
  endtask : t_src

  task automatic t_gpio;
    @(posedge clk_sys);
    gpio_mode <= 1'b1;
    pin_n     <= 1'b0;
    repeat (720) @(posedge clk_sys);
    #1;
    check("gpio low", {14'h0, sys_reset, gpio_in}, 16'h0);
    @(posedge clk_sys);
    pin_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    check("gpio high", {15'h0, gpio_in}, 16'h1);
    @(posedge clk_sys);
    gpio_mode <= 1'b0;
  endtask : t_gpio

  // a later power-on clears every other flag and boots again
  task automatic t_por_again;
    int n;
    check("no boot on others", 16'(cfg_cnt), 16'h1);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    wait_rst(1'b0, REL + 50, n);
    check("boot again", 16'(cfg_cnt), 16'h2);
    rd_chk(RPM_ADDR_CAUSE, RPM_CAUSE_RST, "por clears");
  endtask : t_por_again

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst       = 1'b1;
    bus       = '0;
    pin_n     = 1'b1;
    gpio_mode = 1'b0;
    wdt_ovf   = 1'b0;
    wdt_en    = 1'b0;
    bo_trip   = 1'b0;
    dbg_req   = 1'b0;
    wake      = 1'b0;
    ls_keep   = 1'b1;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_power_on();
    t_cause_bits();
    t_idle();
    t_deep(1'b1);
    t_deep(1'b0);
    t_pin_reset();
    t_src(0, 1'b0, 8'h00);
    t_src(0, 1'b1, 8'h21);
    t_src(2, 1'b0, 8'h00);
    t_src(2, 1'b1, 8'h09);
    t_src(1, 1'b1, 8'h11);
    t_gpio();
    t_por_again();
    tally_and_finish();
  end

endmodule : rpm_top_tb
